// >>> hw/adc_ctl_pkg.sv
/*
  Package for the converter control block: register offsets, field
  positions, reset values, channel codes and cycle counts.
  Assumes a 32-bit Avalon-MM slave with word-aligned registers.
*/
package adc_ctl_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] status_control_off = 4'h0;
  localparam logic [3:0] conversion_result_off = 4'h4;
  localparam logic [3:0] clock_config_off = 4'h8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int flag_pos = 7;
  localparam int irq_en_pos = 6;
  localparam int cont_pos = 5;
  localparam int src_pos = 4;

  // ----------------------------------------------------------------
  // Reset values and channel codes
  // ----------------------------------------------------------------
  localparam logic [4:0] chan_reset = 5'h1F;
  localparam logic [4:0] chan_power_off = 5'h1F;
  localparam logic [4:0] chan_last_ext = 5'h0E;
  localparam logic [4:0] chan_ref_high = 5'h1D;
  localparam logic [4:0] chan_ref_low = 5'h1E;
  localparam logic [4:0] chan_reserved = 5'h1B;
  localparam logic [2:0] prescale_reset = 3'h0;
  localparam logic src_reset = 1'b0;

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam logic [4:0] conv_cycles = 5'h10;
  localparam logic [3:0] div_max_idx = 4'h4;

  // Analog input route for the multiplexer
  typedef enum logic [1:0] {
    route_external = 2'b00,
    route_ref_high = 2'b01,
    route_ref_low = 2'b10,
    route_none = 2'b11
  } route_e;

  // Request to the analog section
  typedef struct packed {
    logic start;
    logic powered;
    route_e route;
    logic [3:0] channel;
    logic bit_strobe;
    logic [2:0] bit_index;
  } analog_req_s;

endpackage

// >>> hw/adc_control.sv
/*
  Control for an 8-bit successive-approximation converter: register
  file over Avalon-MM, channel select, clock source and prescale, and
  the sixteen-clock conversion sequence.
  Assumes the comparator answers within one core clock of a bit strobe,
  and xtal_clk_in is a level synchronous to core_clk.
*/
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps

// Summary of operation
// - With interrupts off, flag sets at each conversion end; flag is read-only.
// - Flag stays set until the result register is read or a conversion ends with interrupts on.
// - With interrupts on, flag never sets and reads as zero.
// - With interrupts on, raise a request at each conversion end.
// - Reading result or writing status/control clears pending request.
// - Reset clears flag, enable, continuous; channel field resets to all ones.
// - Continuous bit repeats conversions; otherwise one conversion only.
// - Five-bit channel field, codes 0 to 14 pick external inputs.
// - Codes 0x0F-0x1A, 0x1C unused; 0x1B reserved; result unknown.
// - Code 0x1D routes high reference, 0x1E routes low reference.
// - All-ones channel code powers the converter off.
// - One 8-bit result register loaded at every conversion end.
// - Three-bit prescale divides by 1, 2, 4, 8, or 16.
// - Source bit picks bus clock at 1, crystal at 0; reset picks crystal.
// - Conversion takes sixteen conversion clocks, starts at next one after write.
// - Continuous results overwrite old ones until the bit is cleared.
// - Selected channel pin is forced to analog input.
module adc_control
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic xtal_clk_in,
  input wire logic comparator_in,
  output adc_ctl_pkg::analog_req_s analog_req,
  output logic [14:0] pin_analog_force,
  output logic conversion_irq
);

  // ----------------------------------------------------------------
  // Types and functions
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wait_edge = 2'b01,
    st_convert = 2'b10
  } conv_state_e;

  // Divider terminal mask for a prescale code
  function automatic logic [3:0] div_mask(input logic [2:0] code);
    logic [3:0] m;
    m = 4'h0;
    unique case (code)
      3'h0: m = 4'h0;
      3'h1: m = 4'h1;
      3'h2: m = 4'h3;
      3'h3: m = 4'h7;
      default: m = 4'hF;
    endcase
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic flag_reg;
  logic irq_en_reg;
  logic cont_reg;
  logic [4:0] chan_reg;
  logic [7:0] result_reg;
  logic [2:0] prescale_reg;
  logic src_reg;
  logic irq_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  conv_state_e state_reg;
  logic [4:0] cyc_reg;
  logic [3:0] div_reg;
  logic src_prev_reg;
  logic [7:0] sar_reg;
  logic start_reg;
  logic strobe_reg;
  logic [2:0] bit_idx_reg;

  logic wr_stat;
  logic rd_result;
  logic src_edge;
  logic tick;
  logic done;
  logic powered;
  logic [7:0] sar_next;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // One wait cycle: answer on the edge after the request appears
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata = rdata_reg;
  assign wr_stat = clk_en & avs_write & ack_reg & avs_byteenable[0]
    & (avs_address == adc_ctl_pkg::status_control_off);
  assign rd_result = clk_en & avs_read & ack_reg
    & (avs_address == adc_ctl_pkg::conversion_result_off);

  // Acknowledge toggles once per request
  always_ff @(posedge core_clk)
  begin
    if (srst)
      ack_reg <= 1'b0;
    else if (clk_en)
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
  end

  // Read data mux, unmapped reads give zero
  always_ff @(posedge core_clk)
  begin
    if (srst)
      rdata_reg <= 32'h0;
    else if (clk_en && avs_read && !ack_reg)
    begin
      unique case (avs_address)
        adc_ctl_pkg::status_control_off:
          rdata_reg <= {24'h0, flag_reg & ~irq_en_reg, irq_en_reg,
            cont_reg, chan_reg};
        adc_ctl_pkg::conversion_result_off:
          rdata_reg <= {24'h0, result_reg};
        adc_ctl_pkg::clock_config_off:
          rdata_reg <= {24'h0, prescale_reg, src_reg, 4'h0};
        default:
          rdata_reg <= 32'h0;
      endcase
    end
  end

  // Control fields; flag bit of the write is ignored
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      irq_en_reg <= 1'b0;
      cont_reg <= 1'b0;
      chan_reg <= adc_ctl_pkg::chan_reset;
    end
    else if (wr_stat)
    begin
      irq_en_reg <= avs_writedata[adc_ctl_pkg::irq_en_pos];
      cont_reg <= avs_writedata[adc_ctl_pkg::cont_pos];
      chan_reg <= avs_writedata[4:0];
    end
  end

  // Clock configuration
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      prescale_reg <= adc_ctl_pkg::prescale_reset;
      src_reg <= adc_ctl_pkg::src_reset;
    end
    else if (clk_en && avs_write && ack_reg && avs_byteenable[0]
      && avs_address == adc_ctl_pkg::clock_config_off)
    begin
      prescale_reg <= avs_writedata[7:5];
      src_reg <= avs_writedata[adc_ctl_pkg::src_pos];
    end
  end

  // ----------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------
  // Bus source ticks every cycle; crystal source on its rising edges
  always_ff @(posedge core_clk)
  begin
    if (srst)
      src_prev_reg <= 1'b0;
    else if (clk_en)
      src_prev_reg <= xtal_clk_in;
  end
  assign src_edge = src_reg ? 1'b1 : (xtal_clk_in & ~src_prev_reg);

  // Prescale counter
  always_ff @(posedge core_clk)
  begin
    if (srst)
      div_reg <= 4'h0;
    else if (clk_en && src_edge)
      div_reg <= ((div_reg & div_mask(prescale_reg))
        == div_mask(prescale_reg)) ? 4'h0 : div_reg + 4'h1;
  end
  assign tick = clk_en & src_edge
    & ((div_reg & div_mask(prescale_reg)) == div_mask(prescale_reg));

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  assign powered = (chan_reg != adc_ctl_pkg::chan_power_off);
  assign done = tick && (state_reg == st_convert)
    && (cyc_reg == adc_ctl_pkg::conv_cycles - 5'h1);

  // State: write arms, next conversion clock starts, sixteen clocks run
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_reg <= st_idle;
      cyc_reg <= 5'h0;
    end
    else if (wr_stat)
    begin
      state_reg <= (avs_writedata[4:0] != adc_ctl_pkg::chan_power_off)
        ? st_wait_edge : st_idle;
      cyc_reg <= 5'h0;
    end
    else if (clk_en && !powered)
      state_reg <= st_idle;
    else if (tick)
    begin
      unique case (state_reg)
        st_idle:
          state_reg <= st_idle;
        st_wait_edge:
        begin
          state_reg <= st_convert;
          cyc_reg <= 5'h0;
        end
        st_convert:
        begin
          if (cyc_reg == adc_ctl_pkg::conv_cycles - 5'h1)
          begin
            state_reg <= cont_reg ? st_convert : st_idle;
            cyc_reg <= 5'h0;
          end
          else
            cyc_reg <= cyc_reg + 5'h1;
        end
        default:
          state_reg <= st_idle;
      endcase
    end
  end

  // Bit decisions: strobes at conversion clocks 1..8, sample next clock
  assign sar_next = sar_reg | (comparator_in ? 8'h00
    : (8'h80 >> bit_idx_reg));
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sar_reg <= 8'h00;
      start_reg <= 1'b0;
      strobe_reg <= 1'b0;
      bit_idx_reg <= 3'h0;
    end
    else if (clk_en)
    begin
      // One start pulse per conversion, none on a rewrite
      start_reg <= !wr_stat && ((tick && state_reg == st_wait_edge)
        || (done && cont_reg));
      strobe_reg <= 1'b0;
      if (strobe_reg)
        sar_reg <= sar_next & ~(8'h80 >> bit_idx_reg)
          | ({8{comparator_in}} & (8'h80 >> bit_idx_reg));
      if (tick && state_reg == st_convert && cyc_reg == 5'h0)
        sar_reg <= 8'h00;
      if (tick && state_reg == st_convert && cyc_reg >= 5'h1
        && cyc_reg <= 5'h8)
      begin
        strobe_reg <= 1'b1;
        bit_idx_reg <= 3'(cyc_reg - 5'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Result, flag and interrupt
  // ----------------------------------------------------------------
  // Result loads at every conversion end
  always_ff @(posedge core_clk)
  begin
    if (srst)
      result_reg <= 8'h00;
    else if (done)
      result_reg <= sar_reg;
  end

  // Completion flag; set wins over the clearing read
  always_ff @(posedge core_clk)
  begin
    if (srst)
      flag_reg <= 1'b0;
    else if (done && !irq_en_reg)
      flag_reg <= 1'b1;
    else if (done && irq_en_reg)
      flag_reg <= 1'b0;
    else if (rd_result)
      flag_reg <= 1'b0;
  end

  // Interrupt request; set wins over clears
  always_ff @(posedge core_clk)
  begin
    if (srst)
      irq_reg <= 1'b0;
    else if (done && irq_en_reg)
      irq_reg <= 1'b1;
    else if (rd_result || wr_stat)
      irq_reg <= 1'b0;
  end
  assign conversion_irq = irq_reg;

  // ----------------------------------------------------------------
  // Analog side
  // ----------------------------------------------------------------
  // Route decode and pin forcing
  always_comb
  begin
    analog_req.start = start_reg;
    analog_req.powered = powered;
    analog_req.bit_strobe = strobe_reg;
    analog_req.bit_index = bit_idx_reg;
    analog_req.channel = chan_reg[3:0];
    pin_analog_force = 15'h0000;
    if (chan_reg <= adc_ctl_pkg::chan_last_ext)
    begin
      analog_req.route = adc_ctl_pkg::route_external;
      pin_analog_force[chan_reg[3:0]] = 1'b1;
    end
    else if (chan_reg == adc_ctl_pkg::chan_ref_high)
      analog_req.route = adc_ctl_pkg::route_ref_high;
    else if (chan_reg == adc_ctl_pkg::chan_ref_low)
      analog_req.route = adc_ctl_pkg::route_ref_low;
    else
      analog_req.route = adc_ctl_pkg::route_none;
  end

endmodule // adc_control

// >>> verification/adc_control_asserts.sv
/*
  Port checker for the converter control block.
  Assumes a single core clock; checks pause while clk_en is low.
*/
`timescale 1ns/100ps
module adc_control_asserts
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire adc_ctl_pkg::analog_req_s analog_req,
  input wire logic [14:0] pin_analog_force,
  input wire logic conversion_irq
);
  // ----------------------------------------------------------------
  // Bus, routing and interrupt relations
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst || !clk_en);
  wait_one_a: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("wait cycle");
  idle_nowait_a: assert property (!(avs_read || avs_write) |->
    !avs_waitrequest) else $error("wait while idle");
  upper_zero_a: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:8] == 24'h0) else $error("upper read bits");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest &&
    !(avs_address inside {4'h0, 4'h4, 4'h8}) |-> avs_readdata == 32'h0)
    else $error("unmapped read");
  force_onehot_a: assert property (
    analog_req.route == adc_ctl_pkg::route_external |->
    pin_analog_force == (15'h1 << analog_req.channel))
    else $error("pin force");
  force_none_a: assert property (
    analog_req.route != adc_ctl_pkg::route_external |->
    pin_analog_force == 15'h0) else $error("pin force idle");
  power_off_a: assert property (!analog_req.powered |->
    analog_req.route == adc_ctl_pkg::route_none && !analog_req.start)
    else $error("power off");
  irq_read_a: assert property (avs_read && !avs_waitrequest &&
    avs_address == 4'h4 |=> !conversion_irq) else $error("irq read");
  irq_write_a: assert property (avs_write && !avs_waitrequest &&
    avs_address == 4'h0 |=> !conversion_irq) else $error("irq write");
  reset_state_a: assert property ($fell(srst) |->
    !conversion_irq && !analog_req.powered) else $error("reset state");
endmodule // adc_control_asserts

bind adc_control adc_control_asserts i_chk (.core_clk(core_clk),
  .srst(srst), .clk_en(clk_en), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .analog_req(analog_req), .pin_analog_force(pin_analog_force),
  .conversion_irq(conversion_irq));

// >>> verification/adc_analog_model.sv
/*
  Comparator and multiplexer model on the analog side.
  Assumes a decision must stand while the bit strobe stands.
*/
`timescale 1ns/100ps
module adc_analog_model
(
  input wire logic core_clk,
  input wire adc_ctl_pkg::analog_req_s analog_req,
  input wire logic [7:0] ext_base,
  output logic comparator_in
);
  logic [7:0] level;
  logic noise = 1'b0;
  // Voltage presented for the current route
  always_comb
  begin
    case (analog_req.route)
      adc_ctl_pkg::route_ref_high: level = 8'hFF;
      adc_ctl_pkg::route_ref_low: level = 8'h00;
      default: level = ext_base ^ {4'h0, analog_req.channel};
    endcase
  end
  // Changing line between decisions
  always @(posedge core_clk)
  begin
    noise <= ~noise;
  end
  // Decision while a strobe stands, the changing line otherwise
  always_comb
  begin
    if (analog_req.bit_strobe && analog_req.powered)
      comparator_in = level[3'h7 - analog_req.bit_index];
    else
      comparator_in = noise;
  end
endmodule // adc_analog_model

// >>> verification/adc_control_and_clock_select_bench.sv
/*
  Self-checking bench for the converter control block.
  Assumes the checker is bound and the analog model stands beside it.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected %0t got %h want %h", $time, (a), (b)); end end
module adc_control_and_clock_select_bench;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic xtal_clk_in = 1'b0;
  logic clk_en = 1'b1;
  logic comparator_in;
  adc_ctl_pkg::analog_req_s analog_req;
  adc_ctl_pkg::analog_req_s snap;
  logic [14:0] pin_analog_force;
  logic conversion_irq;
  logic [7:0] ext_base = 8'h00;
  logic [31:0] q;
  int err_total = 0;
  int check_count = 0;
  int seed = 32'h70fc;
  int starts = 0;
  int xcnt = 0;
  int n, ch, p, dv, bs, want, s0;
  // Clock, crystal level with a rising edge every six cycles
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    xcnt <= (xcnt == 2) ? 0 : xcnt + 1;
    if (xcnt == 2)
      xtal_clk_in <= ~xtal_clk_in;
    if (analog_req.start === 1'b1)
      starts <= starts + 1;
  end
  adc_control i_dut (.core_clk(core_clk), .srst(srst), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .xtal_clk_in(xtal_clk_in),
    .comparator_in(comparator_in), .analog_req(analog_req),
    .pin_analog_force(pin_analog_force), .conversion_irq(conversion_irq));
  adc_analog_model i_ana (.core_clk(core_clk), .analog_req(analog_req),
    .ext_base(ext_base), .comparator_in(comparator_in));
  // Expected result for a channel code
  function automatic logic [7:0] model_res(int c);
    return (c == 29) ? 8'hFF : (c == 30) ? 8'h00 : ext_base ^ c[7:0];
  endfunction
  // One Avalon-MM transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h0, d};
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wrap_up;
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #(50 * 40000);
    err_total++;
    wrap_up();
  end
  // Main sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b0, 4 * i, 8'h00);
      `CHK(q, (i == 0) ? 32'h1F : 32'h0)
    end
    for (int i = 0; i < 9; i++)
    begin
      p = i % 8;
      bs = (i < 8) ? 1 : 6;
      dv = (p >= 4) ? 16 : (1 << p);
      want = 16 * dv * bs;
      ch = $unsigned($random(seed)) % 15;
      ext_base <= 8'($random(seed));
      bus(1'b1, 4'h8, {p[2:0], i < 8, 4'h0});
      bus(1'b0, 4'h8, 8'h00);
      `CHK(q[7:0], {p[2:0], i < 8, 4'h0})
      bus(1'b1, 4'h0, {3'b010, ch[4:0]});
      @(posedge core_clk);
      `CHK(pin_analog_force, 15'h1 << ch)
      for (n = 0; analog_req.start !== 1'b1 && n < 400; n++)
        @(posedge core_clk);
      for (n = 0; conversion_irq !== 1'b1 && n < 2000; n++)
        @(posedge core_clk);
      `CHK(n >= want - 1 && n <= want + dv * bs + 2, 1'b1)
      bus(1'b0, 4'h0, 8'h00);
      `CHK(q[7:0], {3'b010, ch[4:0]})
      bus(1'b0, 4'h4, 8'h00);
      `CHK(q[7:0], model_res(ch))
      @(posedge core_clk);
      `CHK(conversion_irq, 1'b0)
    end
    ch = $unsigned($random(seed)) % 15;
    bus(1'b1, 4'h0, {3'b000, ch[4:0]});
    s0 = starts;
    n = 0;
    do
    begin
      bus(1'b0, 4'h0, 8'h00);
      n++;
    end
    while (q[7] !== 1'b1 && n < 50);
    `CHK(q[7:0], {3'b100, ch[4:0]})
    repeat (60) @(posedge core_clk);
    `CHK(starts - s0, 1)
    bus(1'b0, 4'h0, 8'h00);
    `CHK(q[7], 1'b1)
    bus(1'b0, 4'h4, 8'h00);
    `CHK(q[7:0], model_res(ch))
    bus(1'b0, 4'h0, 8'h00);
    `CHK(q[7], 1'b0)
    for (int k = 29; k < 31; k++)
    begin
      bus(1'b1, 4'h0, {3'b001, k[4:0]});
      repeat (220) @(posedge core_clk);
      bus(1'b0, 4'h4, 8'h00);
      `CHK(q[7:0], model_res(k))
      repeat (110) @(posedge core_clk);
      bus(1'b0, 4'h0, 8'h00);
      `CHK(q[7], 1'b1)
    end
    // Clock enable low freezes a running conversion
    @(posedge core_clk);
    clk_en <= 1'b0;
    @(posedge core_clk);
    snap = analog_req;
    repeat (200) @(posedge core_clk);
    `CHK(analog_req, snap)
    clk_en <= 1'b1;
    bus(1'b1, 4'h0, 8'h1F);
    @(posedge core_clk);
    s0 = starts;
    repeat (60) @(posedge core_clk);
    `CHK(starts - s0, 0)
    `CHK(analog_req.powered, 1'b0)
    wrap_up();
  end
endmodule // adc_control_and_clock_select_bench
